// ==== rtl/dlc_pkg.sv ====
`default_nettype none
package dlc_pkg;
  // Register offsets
  localparam logic [7:0]  ADDR_OFFSET      = 8'h48;
  localparam logic [7:0]  ADDR_STEP        = 8'h4C;
  localparam logic [7:0]  ADDR_CTRL_ONE    = 8'h70;
  localparam logic [7:0]  ADDR_CONST       = 8'h72;
  localparam logic [7:0]  ADDR_CTRL_TWO    = 8'h73;
  localparam logic [7:0]  ADDR_SYNC        = 8'h74;
  // Reset values
  localparam logic [7:0]  RST_OFFSET       = 8'h00;
  localparam logic [4:0]  RST_STEP         = 5'h02;
  localparam logic [3:0]  RST_DARK_CODE    = 4'h4;
  localparam logic        RST_CORR_EN      = 1'b1;
  localparam logic        RST_AVG_SEL      = 1'b0;
  localparam logic [7:0]  RST_CONST        = 8'h2A;
  localparam logic [9:0]  RST_DARK_START   = 10'h2F7;
  localparam logic [3:0]  RST_SYNC         = 4'h0;
  // Field positions
  localparam int          CODE_MSB         = 3;
  localparam int          RESERVED_BIT     = 4;
  localparam int          CORR_EN_BIT      = 5;
  localparam int          AVG_SEL_BIT      = 11;
  localparam int          STEP_MSB         = 4;
  localparam int          START_MSB        = 9;
  localparam int          INV_LINE_BIT     = 0;
  localparam int          INV_FRAME_BIT    = 1;
  localparam int          XOR_BIT          = 2;
  localparam int          CONT_BIT         = 3;
  localparam logic        RESERVED_VALUE   = 1'b1;
  // Calibration offset limits
  localparam logic signed [9:0] OFFSET_MAX = 10'sh07F;
  localparam logic signed [9:0] OFFSET_MIN = -10'sh07F;
  // Reciprocal scaling for the dark average
  localparam int          RECIP_SHIFT      = 16;

  function automatic logic [4:0] dark_count(input logic [3:0] code);
    unique case (code)
      4'h0:    dark_count = 5'h02;
      4'h1:    dark_count = 5'h04;
      4'h2:    dark_count = 5'h06;
      4'h8:    dark_count = 5'h12;
      default: dark_count = 5'h0A;
    endcase
  endfunction : dark_count

  function automatic logic [15:0] dark_recip(input logic [3:0] code);
    unique case (code)
      4'h0:    dark_recip = 16'h8000;
      4'h1:    dark_recip = 16'h4000;
      4'h2:    dark_recip = 16'h2AAB;
      4'h8:    dark_recip = 16'h0E39;
      default: dark_recip = 16'h199A;
    endcase
  endfunction : dark_recip
endpackage : dlc_pkg
`default_nettype wire

// ==== rtl/dark_level_correction.sv ====
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Calibration offset is 8-bit two's complement, range -127 to 127.
// - Offset read returns user value under manual override, else algorithm result.
// - Automatic offset moves at most the 5-bit step size per frame.
// - Dark pixel count code 0,1,2,4,8 selects 2,4,6,10,18 pixels.
// - Enabled correction subtracts row dark average, adds constant; else pass.
// - Average select uses frame dark average at low gain, else dark columns.
// - Row noise constant is 8 bits, resets to 42, set by software.
// - First dark column is a 10-bit setting, reset 759.
// - Line invert bit drives line qualifier low while data valid in normal mode.
// - Frame invert bit drives frame qualifier low during valid frame.
// - Continuous mode keeps line pulses in vertical blanking; normal mode none.
// - XOR mode without continuous gives continuous line XOR frame.
module dark_level_correction #(
  parameter int PIX_W = 10
) (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  // Register access port of the serial interface
  input  wire logic [7:0]              reg_addr,
  input  wire logic [15:0]             reg_wdata,
  input  wire logic                    reg_write,
  input  wire logic                    reg_read,
  output logic      [15:0]             reg_rdata,
  output logic                         reg_rdata_valid,
  // Calibration inputs and offset
  input  wire logic                    manual_override,
  input  wire logic signed [7:0]       cal_target,
  input  wire logic [PIX_W-1:0]        frame_dark_avg,
  input  wire logic                    low_gain,
  output logic signed [7:0]            analog_offset,
  // Pixel stream in
  input  wire logic [PIX_W-1:0]        pix_in,
  input  wire logic [9:0]              pix_col,
  input  wire logic                    line_active,
  input  wire logic                    cont_line_active,
  input  wire logic                    frame_active,
  // Pixel stream out
  output logic      [PIX_W-1:0]        pix_out,
  output logic                         pix_out_valid,
  output logic                         line_valid_out,
  output logic                         frame_valid_out
);
  // Software registers
  logic signed [7:0] user_offset;
  logic [4:0]        step;
  logic [3:0]        dark_code;
  logic              corr_en;
  logic              avg_sel;
  logic [7:0]        noise_const;
  logic [9:0]        dark_start;
  logic [3:0]        sync_ctrl;
  // Frame-boundary copies
  logic [3:0]        sh_code;
  logic              sh_en;
  logic              sh_sel;
  logic [7:0]        sh_const;
  logic [9:0]        sh_start;
  logic [3:0]        sh_sync;
  // Calibration and dark average state
  logic signed [7:0] cal_offset;
  logic              frame_prev;
  logic              line_prev;
  logic [14:0]       dark_sum;
  logic [4:0]        dark_cnt;
  logic [PIX_W-1:0]  col_avg;

  // Register decode
  wire wr_offset = reg_write && (reg_addr == dlc_pkg::ADDR_OFFSET);
  wire wr_step   = reg_write && (reg_addr == dlc_pkg::ADDR_STEP);
  wire wr_one    = reg_write && (reg_addr == dlc_pkg::ADDR_CTRL_ONE);
  wire wr_const  = reg_write && (reg_addr == dlc_pkg::ADDR_CONST);
  wire wr_two    = reg_write && (reg_addr == dlc_pkg::ADDR_CTRL_TWO);
  wire wr_sync   = reg_write && (reg_addr == dlc_pkg::ADDR_SYNC);

  wire signed [7:0] read_offset = manual_override ? user_offset : cal_offset;
  wire [15:0] ctrl_one_word = {4'h0, avg_sel, 5'h00, corr_en,
                               dlc_pkg::RESERVED_VALUE, dark_code};
  wire [15:0] next_rdata =
      (reg_addr == dlc_pkg::ADDR_OFFSET)   ? {8'h00, read_offset} :
      (reg_addr == dlc_pkg::ADDR_STEP)     ? {11'h000, step} :
      (reg_addr == dlc_pkg::ADDR_CTRL_ONE) ? ctrl_one_word :
      (reg_addr == dlc_pkg::ADDR_CONST)    ? {8'h00, noise_const} :
      (reg_addr == dlc_pkg::ADDR_CTRL_TWO) ? {6'h00, dark_start} :
      (reg_addr == dlc_pkg::ADDR_SYNC)     ? {12'h000, sync_ctrl} : 16'h0000;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      user_offset <= dlc_pkg::RST_OFFSET;
      step        <= dlc_pkg::RST_STEP;
      dark_code   <= dlc_pkg::RST_DARK_CODE;
      corr_en     <= dlc_pkg::RST_CORR_EN;
      avg_sel     <= dlc_pkg::RST_AVG_SEL;
      noise_const <= dlc_pkg::RST_CONST;
      dark_start  <= dlc_pkg::RST_DARK_START;
      sync_ctrl   <= dlc_pkg::RST_SYNC;
    end else begin
      if (wr_offset) user_offset <= reg_wdata[7:0];
      if (wr_step)   step <= reg_wdata[dlc_pkg::STEP_MSB:0];
      if (wr_one) begin
        dark_code <= reg_wdata[dlc_pkg::CODE_MSB:0];
        corr_en   <= reg_wdata[dlc_pkg::CORR_EN_BIT];
        avg_sel   <= reg_wdata[dlc_pkg::AVG_SEL_BIT];
      end
      if (wr_const)  noise_const <= reg_wdata[7:0];
      if (wr_two)    dark_start <= reg_wdata[dlc_pkg::START_MSB:0];
      if (wr_sync)   sync_ctrl <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata       <= 16'h0000;
      reg_rdata_valid <= 1'b0;
    end else begin
      reg_rdata_valid <= reg_read;
      if (reg_read) reg_rdata <= next_rdata;
    end
  end

  // Settings are copied only while no frame runs
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sh_code  <= dlc_pkg::RST_DARK_CODE;
      sh_en    <= dlc_pkg::RST_CORR_EN;
      sh_sel   <= dlc_pkg::RST_AVG_SEL;
      sh_const <= dlc_pkg::RST_CONST;
      sh_start <= dlc_pkg::RST_DARK_START;
      sh_sync  <= dlc_pkg::RST_SYNC;
    end else if (!frame_active) begin
      sh_code  <= dark_code;
      sh_en    <= corr_en;
      sh_sel   <= avg_sel;
      sh_const <= noise_const;
      sh_start <= dark_start;
      sh_sync  <= sync_ctrl;
    end
  end

  // Per-frame step-limited calibration
  wire signed [9:0] target_clamp = (cal_target == 8'sh80) ? dlc_pkg::OFFSET_MIN
                                                          : 10'(cal_target);
  wire signed [9:0] cal_wide  = 10'(cal_offset);
  wire signed [9:0] step_wide = signed'({5'h00, step});
  wire signed [9:0] cal_diff  = target_clamp - cal_wide;
  wire signed [9:0] next_cal_wide =
      (cal_diff > step_wide)  ? cal_wide + step_wide :
      (cal_diff < -step_wide) ? cal_wide - step_wide : target_clamp;
  wire frame_end = frame_prev && !frame_active;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cal_offset    <= dlc_pkg::RST_OFFSET;
      frame_prev    <= 1'b0;
      analog_offset <= dlc_pkg::RST_OFFSET;
    end else begin
      frame_prev    <= frame_active;
      analog_offset <= read_offset;
      if (frame_end) cal_offset <= next_cal_wide[7:0];
    end
  end

  // Dark column averaging
  wire [4:0]  dark_n     = dlc_pkg::dark_count(sh_code);
  wire [15:0] dark_rc    = dlc_pkg::dark_recip(sh_code);
  wire [10:0] dark_end   = {1'b0, sh_start} + {6'h00, dark_n};
  wire        in_dark    = line_active && ({1'b0, pix_col} >= {1'b0, sh_start})
                           && ({1'b0, pix_col} < dark_end);
  wire        line_start = line_active && !line_prev;
  wire [14:0] base_sum   = line_start ? 15'h0000 : dark_sum;
  wire [4:0]  base_cnt   = line_start ? 5'h00 : dark_cnt;
  wire [14:0] next_sum   = base_sum + 15'(pix_in);
  wire [30:0] avg_prod   = next_sum * dark_rc;
  wire        avg_done   = in_dark && (base_cnt + 5'h01 == dark_n);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      line_prev <= 1'b0;
      dark_sum  <= 15'h0000;
      dark_cnt  <= 5'h00;
      col_avg   <= '0;
    end else begin
      line_prev <= line_active;
      dark_sum  <= in_dark ? next_sum : base_sum;
      dark_cnt  <= in_dark ? base_cnt + 5'h01 : base_cnt;
      if (avg_done) col_avg <= avg_prod[dlc_pkg::RECIP_SHIFT +: PIX_W];
    end
  end

  // Correction
  wire [PIX_W-1:0]       dark_avg = (sh_sel && low_gain) ? frame_dark_avg : col_avg;
  wire signed [PIX_W+2:0] corr_raw = signed'({3'b000, pix_in}) - signed'({3'b000, dark_avg})
                                     + signed'((PIX_W+3)'(sh_const));
  wire [PIX_W-1:0] corr_clip = corr_raw[PIX_W+2] ? '0 :
                               (|corr_raw[PIX_W+1:PIX_W]) ? '1 : corr_raw[PIX_W-1:0];
  wire [PIX_W-1:0] next_pix = sh_en ? corr_clip : pix_in;

  // Qualifier shaping
  wire sync_inv_line  = sh_sync[dlc_pkg::INV_LINE_BIT];
  wire sync_inv_frame = sh_sync[dlc_pkg::INV_FRAME_BIT];
  wire sync_xor       = sh_sync[dlc_pkg::XOR_BIT];
  wire sync_cont      = sh_sync[dlc_pkg::CONT_BIT];
  wire lv_cont = cont_line_active;
  wire lv_sel  = sync_cont ? lv_cont :
                 sync_xor ? (lv_cont ^ frame_active) :
                 (line_active && frame_active);
  wire next_lv = lv_sel ^ sync_inv_line;
  wire next_fv = frame_active ^ sync_inv_frame;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pix_out         <= '0;
      pix_out_valid   <= 1'b0;
      line_valid_out  <= 1'b0;
      frame_valid_out <= 1'b0;
    end else begin
      pix_out         <= next_pix;
      pix_out_valid   <= line_active && frame_active;
      line_valid_out  <= next_lv;
      frame_valid_out <= next_fv;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  offset_range_a: assert property (cal_offset != 8'sh80)
    else $error("calibration offset reached -128");
  offset_read_a: assert property (reg_read && reg_addr == dlc_pkg::ADDR_OFFSET |=>
      reg_rdata == {8'h00, $past(manual_override) ? $past(user_offset) : $past(cal_offset)})
    else $error("offset readback source wrong");
  step_limit_a: assert property (frame_end |=>
      ((10'(cal_offset) - 10'($past(cal_offset)) <= signed'({5'h00, $past(step)})) &&
       (10'($past(cal_offset)) - 10'(cal_offset) <= signed'({5'h00, $past(step)}))))
    else $error("offset moved more than the step");
  cal_hold_a: assert property (!frame_end |=> $stable(cal_offset))
    else $error("offset changed outside frame end");
  dark_count_a: assert property (avg_done |->
      dark_cnt + 5'h01 == ((sh_code == 4'h0) ? 5'h02 : (sh_code == 4'h1) ? 5'h04 :
                           (sh_code == 4'h2) ? 5'h06 : (sh_code == 4'h8) ? 5'h12 : 5'h0A))
    else $error("dark average taken at wrong count");
  bypass_a: assert property (!sh_en |=> pix_out == $past(pix_in))
    else $error("uncorrected pixel altered");
  line_inv_a: assert property (line_active && frame_active && !sync_cont
      && !sync_xor |=> line_valid_out == !$past(sync_inv_line))
    else $error("line qualifier sense wrong");
  frame_inv_a: assert property (frame_active |=>
      frame_valid_out == !$past(sync_inv_frame))
    else $error("frame qualifier sense wrong");
  vblank_quiet_a: assert property (!frame_active && !sync_cont && !sync_xor |=>
      line_valid_out == $past(sync_inv_line))
    else $error("line qualifier during vertical blank");
  cont_mode_a: assert property (sync_cont |=>
      line_valid_out == ($past(cont_line_active) ^ $past(sync_inv_line)))
    else $error("continuous line qualifier wrong");
  xor_mode_a: assert property (sync_xor && !sync_cont |=>
      line_valid_out == ($past(cont_line_active) ^ $past(frame_active) ^ $past(sync_inv_line)))
    else $error("xor line qualifier wrong");
  frame_stable_a: assert property (frame_active && $past(frame_active) |->
      $stable(sh_sync) && $stable(sh_en) && $stable(sh_const)
      && $stable(sh_code) && $stable(sh_sel) && $stable(sh_start))
    else $error("settings changed inside a frame");

  corr_frame_c: cover property (sh_en && avg_done ##[1:50] pix_out_valid);
  cal_step_c:   cover property (frame_end && cal_diff > step_wide);
  xor_mode_c:   cover property (sync_xor && !frame_active && cont_line_active);
endmodule : dark_level_correction
`default_nettype wire

// ==== dv/capture_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module capture_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // Stream from the block
  input  wire logic [9:0] pix_out,
  input  wire logic       pix_out_valid,
  // Newest captured pixel
  output logic      [9:0] last_pix
);
  always_ff @(posedge core_clk) begin
    if (reset) last_pix <= 10'h000;
    else if (pix_out_valid) last_pix <= pix_out;
  end
endmodule : capture_model
`default_nettype wire

// ==== dv/dark_level_correction_and_sync_out_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module dark_level_correction_and_sync_out_test;
  logic              core_clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  logic              manual_override = 1'b0, low_gain = 1'b0, line_active = 1'b0;
  logic              cont_line_active = 1'b0, frame_active = 1'b0;
  logic [7:0]        reg_addr = 8'h00;
  logic [15:0]       reg_wdata = 16'h0000;
  logic signed [7:0] cal_target = 8'sh00;
  logic [9:0]        frame_dark_avg = 10'h000, pix_in = 10'h000, pix_col = 10'h000;
  logic [15:0]       reg_rdata;
  logic              reg_rdata_valid, pix_out_valid, line_valid_out, frame_valid_out;
  logic signed [7:0] analog_offset;
  logic [9:0]        pix_out, last_pix;
  int                err_total = 0, checks_done = 0;
  always #10 core_clk = ~core_clk;
  dark_level_correction #(.PIX_W(10)) dut (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .manual_override(manual_override),
    .cal_target(cal_target), .frame_dark_avg(frame_dark_avg), .low_gain(low_gain),
    .analog_offset(analog_offset), .pix_in(pix_in), .pix_col(pix_col),
    .line_active(line_active), .cont_line_active(cont_line_active),
    .frame_active(frame_active), .pix_out(pix_out), .pix_out_valid(pix_out_valid),
    .line_valid_out(line_valid_out), .frame_valid_out(frame_valid_out));
  capture_model model (.core_clk(core_clk), .reset(reset), .pix_out(pix_out),
    .pix_out_valid(pix_out_valid), .last_pix(last_pix));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  task automatic cmp(input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic chk_reg(input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    for (int n = 0; reg_rdata_valid !== 1'b1; n++) begin
      if (n == 4) begin
        err_total++;
        wrap_up();
      end
      @(posedge core_clk);
      #1;
    end
    cmp(exp, reg_rdata);
    @(posedge core_clk);
    #1;
    cmp(16'h0000, {15'h0000, reg_rdata_valid});
  endtask : chk_reg
  task automatic px(input logic [9:0] col, input logic [9:0] val);
    @(posedge core_clk);
    pix_col <= col;
    pix_in  <= val;
  endtask : px
  task automatic chk_pix(input logic [9:0] exp);
    repeat (2) @(posedge core_clk);
    #1;
    cmp({6'h00, exp}, {6'h00, last_pix});
  endtask : chk_pix
  task automatic frm(input logic on);
    @(posedge core_clk);
    frame_active     <= on;
    line_active      <= on;
    cont_line_active <= on;
  endtask : frm
  task automatic cyc();
    frm(1'b1);
    frm(1'b0);
  endtask : cyc
  task automatic t_reset();
    logic [7:0]  ra [7] = '{8'h48, 8'h4C, 8'h70, 8'h72, 8'h73, 8'h74, 8'h10};
    logic [15:0] rv [7] = '{16'h0000, 16'h0002, 16'h0034, 16'h002A, 16'h02F7, 16'h0000, 16'h0000};
    wr(8'h10, 16'hFFFF);
    for (int i = 0; i < 7; i++) chk_reg(ra[i], rv[i]);
  endtask : t_reset
  task automatic t_sync();
    // Phases as {frame, line, continuous line}
    logic [2:0] ph [4] = '{3'b001, 3'b111, 3'b100, 3'b000};
    logic       lq;
    for (int v = 0; v < 16; v++) begin
      wr(dlc_pkg::ADDR_SYNC, 16'(v));
      for (int p = 0; p < 4; p++) begin
        @(posedge core_clk);
        {frame_active, line_active, cont_line_active} <= ph[p];
        @(posedge core_clk);
        #1;
        lq = v[3] ? ph[p][0] : (v[2] ? ph[p][0] ^ ph[p][2] : ph[p][1] & ph[p][2]);
        cmp(16'(ph[p][1] & ph[p][2]), 16'(pix_out_valid));
        cmp(16'(lq ^ v[0]), 16'(line_valid_out));
        cmp(16'(ph[p][2] ^ v[1]), 16'(frame_valid_out));
      end
    end
  endtask : t_sync
  task automatic t_codes();
    int         cnt [5] = '{2, 4, 6, 10, 18};
    logic [3:0] code [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
    for (int i = 0; i < 5; i++) begin
      frm(1'b0);
      wr(dlc_pkg::ADDR_CTRL_ONE, {12'h002, code[i]});
      frm(1'b1);
      px(10'h2F7, 10'(10 * cnt[i] + 10));
      for (int k = 1; k <= cnt[i]; k++) px(10'h2F7 + 10'(k), k == cnt[i] ? 10'h1F4 : 10'h00A);
      px(10'h003, 10'h064);
      chk_pix(10'h07A);
    end
  endtask : t_codes
  task automatic t_corr();
    frm(1'b0);
    wr(dlc_pkg::ADDR_CTRL_ONE, 16'h0820);
    frame_dark_avg <= 10'h01E;
    low_gain       <= 1'b1;
    chk_reg(dlc_pkg::ADDR_CTRL_ONE, 16'h0830);
    frm(1'b1);
    px(10'h2F7, 10'h00A);
    px(10'h2F8, 10'h014);
    px(10'h008, 10'h064);
    chk_pix(10'h070);
    @(posedge core_clk);
    low_gain <= 1'b0;
    // New constant written mid-frame must wait for blanking
    wr(dlc_pkg::ADDR_CONST, 16'h0000);
    chk_pix(10'h07F);
    cyc();
    frm(1'b1);
    chk_pix(10'h055);
    frm(1'b0);
    wr(dlc_pkg::ADDR_CTRL_ONE, 16'h0000);
    chk_reg(dlc_pkg::ADDR_CTRL_ONE, 16'h0010);
    frm(1'b1);
    chk_pix(10'h064);
  endtask : t_corr
  task automatic t_cal();
    frm(1'b0);
    // Let the running frame close before the new target is seen
    @(posedge core_clk);
    cal_target <= 8'sh64;
    repeat (2) cyc();
    chk_reg(dlc_pkg::ADDR_OFFSET, 16'h0004);
    cmp(16'h0004, {8'h00, analog_offset});
    frm(1'b0);
    cal_target <= 8'shFF;
    repeat (3) cyc();
    chk_reg(dlc_pkg::ADDR_OFFSET, 16'h00FF);
    wr(dlc_pkg::ADDR_STEP, 16'h001F);
    cal_target <= 8'sh80;
    cyc();
    chk_reg(dlc_pkg::ADDR_OFFSET, 16'h00E0);
    wr(dlc_pkg::ADDR_OFFSET, 16'h0085);
    manual_override <= 1'b1;
    chk_reg(dlc_pkg::ADDR_OFFSET, 16'h0085);
    cmp(16'h0085, {8'h00, analog_offset});
    frm(1'b0);
    manual_override <= 1'b0;
    chk_reg(dlc_pkg::ADDR_OFFSET, 16'h00E0);
  endtask : t_cal
  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_sync();
    t_codes();
    t_corr();
    t_cal();
    wrap_up();
  end
endmodule : dark_level_correction_and_sync_out_test
`default_nettype wire
